// ---- core/bpt_pkg.sv ----
// Package with register map, field positions and shared types of the unit.
package bpt_pkg;
    // Register indices; the bus byte address is four times the index.
    localparam logic [7:0] OFF_CTRL0    = 8'h20;
    localparam logic [7:0] OFF_CTRL1    = 8'h21;
    localparam logic [7:0] OFF_ADDR_HI  = 8'h22;
    localparam logic [7:0] OFF_ADDR_LO  = 8'h23;
    localparam logic [7:0] OFF_SEC_HI   = 8'h24;
    localparam logic [7:0] OFF_SEC_LO   = 8'h25;
    localparam logic [7:0] OFF_TAG_CTRL = 8'h28;
    localparam logic [7:0] OFF_STATUS   = 8'h2C;
    localparam int C0_MODE_HI = 7;
    localparam int C0_MODE_LO = 6;
    localparam int C0_PROG    = 3;
    localparam int C0_RANGE1  = 1;
    localparam int C0_RANGE0  = 0;
    localparam int C1_SEC_EN  = 7;
    localparam int C1_MASK_HI = 6;
    localparam int C1_MASK_LO = 5;
    localparam int C1_SZ8     = 4;
    localparam int C1_RW1E    = 3;
    localparam int C1_RW1     = 2;
    localparam int C1_RW0E    = 1;
    localparam int C1_RW0     = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY  = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        BPT_OFF, BPT_SWI_DUAL, BPT_BGD_FULL, BPT_BGD_DUAL
    } bpt_mode_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic        read;
        logic        valid;
        logic        fetch;
    } bpt_cpu_bus_type;

    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] addr_hi;
        logic [7:0] addr_lo;
        logic [7:0] sec_hi;
        logic [7:0] sec_lo;
        logic       tag_active;
        logic       ecl_prev;
        logic       tag_lo_seen;
        logic       tag_hi_seen;
        logic       pend_break;
        logic       pend_prog;
        logic       swi_req;
        logic       bgd_req;
        logic       tag_bgd_req;
        logic       tagged_hi;
        logic       tagged_lo;
        logic       awvalid_seen;
        logic [7:0] awaddr;
        logic       wvalid_seen;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bpt_state_type;
endpackage : bpt_pkg

// ---- core/bpt_unit.sv ----
// Breakpoint comparator and instruction tag unit with an AXI4-Lite slave.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module bpt_unit (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     clk_en,
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire bpt_pkg::bpt_cpu_bus_type cpu_bus,
    input  wire logic                     insn_boundary,
    input  wire logic                     queue_head_hi,
    input  wire logic                     queue_head_lo,
    input  wire logic                     head_executes,
    input  wire logic                     bgd_active,
    input  wire logic                     tag_and_go_command,
    input  wire logic                     bus_e_clock,
    input  wire logic                     low_tag_pin,
    input  wire logic                     high_tag_pin,
    output logic                          swi_request,
    output logic                          bgd_request,
    output logic                          tag_mode_active,
    output logic                          serial_cmd_block,
    output logic                          tag_hi_out,
    output logic                          tag_lo_out
);
    bpt_pkg::bpt_state_type st_r;
    bpt_pkg::bpt_state_type st_nxt;

    // Picks one byte of a word bus by its byte lane.
    function automatic logic [7:0] lane_byte(input logic [31:0] w,
                                             input logic [1:0] lane);
        lane_byte = w[8*lane +: 8];
    endfunction : lane_byte

    // Read view of a register at a register index; unmapped returns zero.
    function automatic logic [7:0] reg_view(input bpt_pkg::bpt_state_type s,
                                            input logic [7:0] a);
        if (a == bpt_pkg::OFF_CTRL0)
            reg_view = s.ctrl0;
        else if (a == bpt_pkg::OFF_CTRL1)
            reg_view = s.ctrl1;
        else if (a == bpt_pkg::OFF_ADDR_HI)
            reg_view = s.addr_hi;
        else if (a == bpt_pkg::OFF_ADDR_LO)
            reg_view = s.addr_lo;
        else if (a == bpt_pkg::OFF_SEC_HI)
            reg_view = s.sec_hi;
        else if (a == bpt_pkg::OFF_SEC_LO)
            reg_view = s.sec_lo;
        else if (a == bpt_pkg::OFF_STATUS)
            reg_view = {3'b000, s.tag_active, s.pend_break, s.pend_prog,
                        s.tagged_hi, s.tagged_lo};
        else
            reg_view = 8'h00;
    endfunction : reg_view

    // Registers sit in the low byte lane of each aligned word.
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == bpt_pkg::OFF_CTRL0) || (a == bpt_pkg::OFF_CTRL1) ||
                 (a == bpt_pkg::OFF_ADDR_HI) || (a == bpt_pkg::OFF_ADDR_LO) ||
                 (a == bpt_pkg::OFF_SEC_HI) || (a == bpt_pkg::OFF_SEC_LO) ||
                 (a == bpt_pkg::OFF_TAG_CTRL) || (a == bpt_pkg::OFF_STATUS);
    endfunction : mapped

    // Byte address to register index; a misaligned address hits nothing.
    function automatic logic [7:0] word_index(input logic [7:0] a);
        word_index = (a[1:0] == 2'b00) ? {2'b00, a[7:2]} : 8'hFF;
    endfunction : word_index

    bpt_pkg::bpt_mode_type mode;
    logic        hi0_ok;
    logic        lo0_ok;
    logic        rw0_ok;
    logic        hit0;
    logic        hi1_ok;
    logic        lo1_ok;
    logic        rw1_ok;
    logic        hit1;
    logic        dhi_ok;
    logic        dlo_ok;
    logic        full_hit;
    logic        any_hit;
    logic        prog_only;
    logic        e_fall;
    logic [7:0]  wbyte;
    logic        do_wr;

    always_comb
    begin
        mode = bpt_pkg::bpt_mode_type'(st_r.ctrl0[bpt_pkg::C0_MODE_HI:
                                                  bpt_pkg::C0_MODE_LO]);
        hi0_ok = cpu_bus.addr[15:8] == st_r.addr_hi;
        lo0_ok = !st_r.ctrl0[bpt_pkg::C0_RANGE0] ||
                 cpu_bus.addr[7:0] == st_r.addr_lo;
        rw0_ok = (mode == bpt_pkg::BPT_SWI_DUAL) ||
                 !st_r.ctrl1[bpt_pkg::C1_RW0E] ||
                 cpu_bus.read == st_r.ctrl1[bpt_pkg::C1_RW0];
        hit0 = hi0_ok && lo0_ok && rw0_ok;
        hi1_ok = cpu_bus.addr[15:8] == st_r.sec_hi;
        lo1_ok = !st_r.ctrl0[bpt_pkg::C0_RANGE1] ||
                 cpu_bus.addr[7:0] == st_r.sec_lo;
        rw1_ok = (mode == bpt_pkg::BPT_SWI_DUAL) ||
                 !st_r.ctrl1[bpt_pkg::C1_RW1E] ||
                 cpu_bus.read == st_r.ctrl1[bpt_pkg::C1_RW1];
        // Byte size select is deliberately unused in all modes.
        hit1 = st_r.ctrl1[bpt_pkg::C1_SEC_EN] && hi1_ok && lo1_ok &&
               rw1_ok;
        dhi_ok = st_r.ctrl1[bpt_pkg::C1_MASK_HI] ||
                 cpu_bus.data[15:8] == st_r.sec_hi;
        dlo_ok = st_r.ctrl1[bpt_pkg::C1_MASK_LO] ||
                 cpu_bus.data[7:0] == st_r.sec_lo;
        full_hit = hit0 && (!st_r.ctrl1[bpt_pkg::C1_SEC_EN] ||
                            (dhi_ok && dlo_ok));
        case (mode)
            bpt_pkg::BPT_BGD_FULL: any_hit = full_hit;
            bpt_pkg::BPT_OFF:      any_hit = 1'b0;
            default:               any_hit = hit0 || hit1;
        endcase
        // Interrupt mode only ever breaks on executed fetches.
        prog_only = st_r.ctrl0[bpt_pkg::C0_PROG] ||
                    mode == bpt_pkg::BPT_SWI_DUAL;
        e_fall = st_r.ecl_prev && !bus_e_clock;
        wbyte = lane_byte(st_r.wdata, 2'b00);
        do_wr = st_r.awvalid_seen && st_r.wvalid_seen && !st_r.bvalid;
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.swi_req = 1'b0;
        st_nxt.bgd_req = 1'b0;
        st_nxt.tag_bgd_req = 1'b0;
        st_nxt.ecl_prev = bus_e_clock;
        if (st_r.pend_break && insn_boundary)
        begin
            st_nxt.pend_break = 1'b0;
            st_nxt.swi_req = mode == bpt_pkg::BPT_SWI_DUAL;
            st_nxt.bgd_req = mode != bpt_pkg::BPT_SWI_DUAL;
        end
        // A tagged fetch that is discarded never reaches execution.
        if (st_r.pend_prog && insn_boundary)
        begin
            st_nxt.pend_prog = 1'b0;
            if (head_executes)
            begin
                st_nxt.swi_req = mode == bpt_pkg::BPT_SWI_DUAL;
                st_nxt.bgd_req = mode != bpt_pkg::BPT_SWI_DUAL;
            end
        end
        // A hit in the boundary cycle stays pending, so the set wins.
        if (cpu_bus.valid && any_hit && !bgd_active)
        begin
            if (!prog_only)
                st_nxt.pend_break = 1'b1;
            else if (cpu_bus.fetch)
                st_nxt.pend_prog = 1'b1;
        end
        if (tag_and_go_command && !bgd_active)
            st_nxt.tag_active = 1'b1;
        if ((st_r.tagged_hi && queue_head_hi) ||
            (st_r.tagged_lo && queue_head_lo))
        begin
            st_nxt.tag_bgd_req = !bgd_active;
            st_nxt.tagged_hi = 1'b0;
            st_nxt.tagged_lo = 1'b0;
        end
        // A tag caught at the same fall as a head hit is kept.
        if (st_r.tag_active && e_fall)
        begin
            st_nxt.tagged_hi = st_nxt.tagged_hi || !high_tag_pin;
            st_nxt.tagged_lo = st_nxt.tagged_lo || !low_tag_pin;
        end
        if (bgd_active)
        begin
            st_nxt.tag_active = 1'b0;
            st_nxt.pend_break = 1'b0;
            st_nxt.pend_prog = 1'b0;
            st_nxt.swi_req = 1'b0;
            st_nxt.bgd_req = 1'b0;
        end
        if (s_axi_awvalid && !st_r.awvalid_seen)
        begin
            st_nxt.awvalid_seen = 1'b1;
            st_nxt.awaddr = word_index(s_axi_awaddr);
        end
        if (s_axi_wvalid && !st_r.wvalid_seen)
        begin
            st_nxt.wvalid_seen = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (do_wr)
        begin
            st_nxt.awvalid_seen = 1'b0;
            st_nxt.wvalid_seen = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = mapped(st_r.awaddr) ? bpt_pkg::RESP_OKAY
                                               : bpt_pkg::RESP_SLVERR;
            if (st_r.wstrb[0])
            begin
                if (st_r.awaddr == bpt_pkg::OFF_CTRL0)
                    st_nxt.ctrl0 = wbyte;
                else if (st_r.awaddr == bpt_pkg::OFF_CTRL1)
                    st_nxt.ctrl1 = wbyte;
                else if (st_r.awaddr == bpt_pkg::OFF_ADDR_HI)
                    st_nxt.addr_hi = wbyte;
                else if (st_r.awaddr == bpt_pkg::OFF_ADDR_LO)
                    st_nxt.addr_lo = wbyte;
                else if (st_r.awaddr == bpt_pkg::OFF_SEC_HI)
                    st_nxt.sec_hi = wbyte;
                else if (st_r.awaddr == bpt_pkg::OFF_SEC_LO)
                    st_nxt.sec_lo = wbyte;
                else if (st_r.awaddr == bpt_pkg::OFF_TAG_CTRL &&
                         wbyte[0] && !bgd_active)
                    st_nxt.tag_active = 1'b1;
            end
        end
        if (st_r.bvalid && s_axi_bready)
            st_nxt.bvalid = 1'b0;
        if (s_axi_arvalid && !st_r.rvalid)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = {24'h00_0000,
                            reg_view(st_r, word_index(s_axi_araddr))};
            st_nxt.rresp = mapped(word_index(s_axi_araddr))
                           ? bpt_pkg::RESP_OKAY : bpt_pkg::RESP_SLVERR;
        end
        else if (st_r.rvalid && s_axi_rready)
            st_nxt.rvalid = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
            st_r.addr_hi <= bpt_pkg::RESET_BYTE;
            st_r.addr_lo <= bpt_pkg::RESET_BYTE;
            st_r.sec_hi <= bpt_pkg::RESET_BYTE;
            st_r.sec_lo <= bpt_pkg::RESET_BYTE;
            st_r.ecl_prev <= 1'b1;
        end
        else if (clk_en)
            st_r <= st_nxt;
    end

    assign s_axi_awready = !st_r.awvalid_seen;
    assign s_axi_wready = !st_r.wvalid_seen;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign swi_request = st_r.swi_req;
    assign bgd_request = st_r.bgd_req || st_r.tag_bgd_req;
    assign tag_mode_active = st_r.tag_active;
    assign serial_cmd_block = st_r.tag_active;
    assign tag_hi_out = st_r.tagged_hi;
    assign tag_lo_out = st_r.tagged_lo;

    a_off_no_req: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && st_r.ctrl0[7:6] == 2'b00 && !st_r.pend_break &&
        !st_r.pend_prog |=> !st_r.swi_req && !st_r.bgd_req)
        else $error("Request raised with breakpoints off.");
    a_bgd_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && bgd_active |=> !st_r.swi_req && !st_r.bgd_req &&
        !st_r.pend_break)
        else $error("Request while background active.");
    a_bgd_tag_off: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && bgd_active |=> !tag_mode_active)
        else $error("Tagging survived background entry.");
    a_swi_mode_only: assert property (@(posedge aclk) disable iff (!aresetn)
        swi_request |-> $past(mode) == bpt_pkg::BPT_SWI_DUAL)
        else $error("Interrupt request outside interrupt mode.");
    a_swi_no_data: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && mode == bpt_pkg::BPT_SWI_DUAL && cpu_bus.valid &&
        !cpu_bus.fetch && !st_r.pend_prog |=> !st_r.pend_prog)
        else $error("Data access armed an interrupt break.");
    a_req_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && st_r.bgd_req |=> !st_r.bgd_req)
        else $error("Break request longer than one cycle.");
    a_match_arms: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && cpu_bus.valid && any_hit && !bgd_active && !prog_only
        |=> st_r.pend_break)
        else $error("Match did not arm a break.");
    a_tag_sample: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_en && st_r.tag_active && e_fall && !high_tag_pin &&
        !(queue_head_hi || queue_head_lo) |=> tag_hi_out)
        else $error("High tag not captured.");
    a_reg_reset: assert property (@(posedge aclk)
        $rose(aresetn) |-> st_r.addr_hi == 8'h00 && st_r.sec_lo == 8'h00)
        else $error("Compare register not zero after reset.");
    sequence s_armed_at_boundary;
        clk_en && st_r.pend_break && insn_boundary && !bgd_active;
    endsequence
    sequence s_request_raised;
        st_r.swi_req || st_r.bgd_req;
    endsequence
    a_break_fires: assert property (@(posedge aclk) disable iff (!aresetn)
        s_armed_at_boundary |=> s_request_raised)
        else $error("Pending break not taken at the boundary.");
endmodule : bpt_unit

// ---- verification/bpt_cpu_model.sv ----
// Model of the CPU bus, instruction queue and external tag pod.
`timescale 1ns/1ns
module bpt_cpu_model (
    input  wire logic                aclk,
    output bpt_pkg::bpt_cpu_bus_type cpu_bus,
    output logic                     insn_boundary,
    output logic                     head_executes,
    output logic                     queue_head_hi,
    output logic                     queue_head_lo,
    output logic                     bus_e_clock,
    output logic                     low_tag_pin,
    output logic                     high_tag_pin
);
    initial
    begin
        cpu_bus = '0;
        {insn_boundary, head_executes, queue_head_hi, queue_head_lo} = '0;
        {bus_e_clock, low_tag_pin, high_tag_pin} = 3'h7;
    end

    // One bus cycle, an idle cycle, then an instruction boundary.
    task automatic cycle(input logic [15:0] a, d, input logic rd, fe, ex);
        @(posedge aclk);
        cpu_bus <= '{addr: a, data: d, read: rd, valid: 1'b1, fetch: fe};
        @(posedge aclk);
        // A released bus shows the inverse, so a stale match cannot hide.
        cpu_bus <= '{addr: ~a, data: ~d, read: ~rd, valid: 1'b0, fetch: 1'b0};
        @(posedge aclk);
        insn_boundary <= 1'b1;
        head_executes <= ex;
        @(posedge aclk);
        insn_boundary <= 1'b0;
    endtask : cycle

    // Pins are held on both sides of the E clock fall.
    task automatic tag(input logic hi, lo);
        @(posedge aclk);
        {high_tag_pin, low_tag_pin, bus_e_clock} <= {hi, lo, 1'b1};
        @(posedge aclk);
        bus_e_clock <= 1'b0;
        repeat (2) @(posedge aclk);
        {high_tag_pin, low_tag_pin} <= 2'h3;
    endtask : tag

    task automatic head(input logic hi, lo);
        @(posedge aclk);
        {queue_head_hi, queue_head_lo, insn_boundary} <= {hi, lo, 1'b1};
        @(posedge aclk);
        {queue_head_hi, queue_head_lo, insn_boundary} <= 3'h0;
    endtask : head
endmodule : bpt_cpu_model

// ---- verification/bpt_unit_bench.sv ----
// Self-checking bench of the breakpoint and tag unit.
`timescale 1ns/1ns
module bpt_unit_bench;
    logic                     aclk;
    logic                     aresetn;
    logic                     clk_en;
    logic [7:0]               s_axi_awaddr, s_axi_araddr;
    logic [31:0]              s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0]               s_axi_wstrb;
    logic [1:0]               s_axi_bresp, s_axi_rresp, rsp;
    logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                     s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                     s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic                     s_axi_rready, insn_boundary, head_executes;
    logic                     queue_head_hi, queue_head_lo, bgd_active;
    logic                     tag_and_go_command, bus_e_clock;
    logic                     low_tag_pin, high_tag_pin, swi_request;
    logic                     bgd_request, tag_mode_active, serial_cmd_block;
    logic                     tag_hi_out, tag_lo_out;
    bpt_pkg::bpt_cpu_bus_type cpu_bus;
    int                       errors, n_checks, n_swi, n_bgd, cycles;

    bpt_unit i_dut (
        .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_bus,
        .insn_boundary, .queue_head_hi, .queue_head_lo, .head_executes,
        .bgd_active, .tag_and_go_command, .bus_e_clock, .low_tag_pin,
        .high_tag_pin, .swi_request, .bgd_request, .tag_mode_active,
        .serial_cmd_block, .tag_hi_out, .tag_lo_out
    );
    bpt_cpu_model i_cpu (
        .aclk, .cpu_bus, .insn_boundary, .head_executes, .queue_head_hi,
        .queue_head_lo, .bus_e_clock, .low_tag_pin, .high_tag_pin
    );

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Request pulses are counted here so a double pulse is seen as two.
    always @(posedge aclk)
    begin
        if (swi_request === 1'b1) n_swi <= n_swi + 1;
        if (bgd_request === 1'b1) n_bgd <= n_bgd + 1;
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            print_verdict();
        end
    end

    // Task addresses are register indices; registers are a word apart.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= {a[5:0], 2'b00};
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= {a[5:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    // Bus flags f are read, fetch, executes; e is software, background.
    task automatic bp(input logic [7:0] c0, c1, input logic [15:0] a, d,
                      input logic [2:0] f, input logic [1:0] e);
        int s0;
        int b0;
        axi_wr(bpt_pkg::OFF_CTRL0, 32'(c0));
        axi_wr(bpt_pkg::OFF_CTRL1, 32'(c1));
        s0 = n_swi;
        b0 = n_bgd;
        i_cpu.cycle(a, d, f[2], f[1], f[0]);
        repeat (4) @(posedge aclk);
        chk("swi_request", 32'(n_swi - s0), 32'(e[1]));
        chk("bgd_request", 32'(n_bgd - b0), 32'(e[0]));
    endtask : bp

    task automatic t_regs();
        for (int i = 0; i < 6; i++)
        begin
            axi_rd(bpt_pkg::OFF_CTRL0 + 8'(i));
            chk("reset value", rdv, 32'h0000_0000);
        end
        axi_wr(bpt_pkg::OFF_ADDR_HI, 32'h0000_0012);
        axi_wr(bpt_pkg::OFF_ADDR_LO, 32'h0000_0034);
        axi_wr(bpt_pkg::OFF_SEC_HI, 32'h0000_0056);
        axi_wr(bpt_pkg::OFF_SEC_LO, 32'h0000_0078);
        axi_wr(bpt_pkg::OFF_CTRL1, 32'hFFFF_FFFF);
        chk("write resp", 32'(rsp), 32'(bpt_pkg::RESP_OKAY));
        axi_rd(bpt_pkg::OFF_CTRL1);
        chk("ctrl1 readback", rdv, 32'h0000_00FF);
        axi_rd(bpt_pkg::OFF_SEC_LO);
        chk("compare readback", rdv, 32'h0000_0078);
        axi_rd(8'h30);
        chk("unmapped resp", 32'(rsp), 32'(bpt_pkg::RESP_SLVERR));
        chk("unmapped data", rdv, 32'h0000_0000);
    endtask : t_regs

    task automatic t_modes();
        bp(8'h01, 8'h00, 16'h1234, 16'h0000, 3'h7, 2'h0);
        bp(8'h41, 8'h00, 16'h1234, 16'h0000, 3'h7, 2'h2);
        bp(8'h41, 8'h00, 16'h1234, 16'h0000, 3'h5, 2'h0);
        bp(8'h49, 8'h00, 16'h1234, 16'h0000, 3'h7, 2'h2);
        bp(8'hC1, 8'h00, 16'h1234, 16'h0000, 3'h5, 2'h1);
        bp(8'h81, 8'h00, 16'h1234, 16'hFFFF, 3'h5, 2'h1);
        bp(8'hC1, 8'h00, 16'h1299, 16'h0000, 3'h5, 2'h0);
        bp(8'hC0, 8'h00, 16'h1299, 16'h0000, 3'h5, 2'h1);
        bp(8'hC0, 8'h00, 16'h1334, 16'h0000, 3'h5, 2'h0);
    endtask : t_modes

    task automatic t_second();
        bp(8'hC3, 8'h80, 16'h5678, 16'h0000, 3'h5, 2'h1);
        bp(8'hC3, 8'h00, 16'h5678, 16'h0000, 3'h5, 2'h0);
        bp(8'hC1, 8'h80, 16'h56AA, 16'h0000, 3'h5, 2'h1);
        bp(8'hC3, 8'h80, 16'h56AA, 16'h0000, 3'h5, 2'h0);
        bp(8'hC3, 8'h90, 16'h5678, 16'h0000, 3'h5, 2'h1);
        bp(8'h43, 8'h80, 16'h5678, 16'h0000, 3'h7, 2'h2);
        bp(8'h81, 8'h80, 16'h1234, 16'h5678, 3'h5, 2'h1);
        bp(8'h81, 8'h80, 16'h1234, 16'h5600, 3'h5, 2'h0);
        bp(8'h81, 8'hA0, 16'h1234, 16'h5600, 3'h5, 2'h1);
        bp(8'h81, 8'hC0, 16'h1234, 16'h0078, 3'h5, 2'h1);
        bp(8'h81, 8'h80, 16'h1234, 16'h0078, 3'h5, 2'h0);
    endtask : t_second

    task automatic t_dir();
        int nb;
        bp(8'hC1, 8'h03, 16'h1234, 16'h0000, 3'h1, 2'h0);
        bp(8'hC1, 8'h03, 16'h1234, 16'h0000, 3'h5, 2'h1);
        bp(8'hC1, 8'h02, 16'h1234, 16'h0000, 3'h1, 2'h1);
        bp(8'h81, 8'h02, 16'h1234, 16'h0000, 3'h5, 2'h0);
        bp(8'hC3, 8'h8C, 16'h5678, 16'h0000, 3'h1, 2'h0);
        bp(8'hC3, 8'h8C, 16'h5678, 16'h0000, 3'h5, 2'h1);
        bp(8'h41, 8'h02, 16'h1234, 16'h0000, 3'h7, 2'h2);
        bp(8'hC9, 8'h00, 16'h1234, 16'h0000, 3'h5, 2'h0);
        bp(8'hC9, 8'h00, 16'h1234, 16'h0000, 3'h6, 2'h0);
        bp(8'hC9, 8'h00, 16'h1234, 16'h0000, 3'h7, 2'h1);
        @(posedge aclk);
        bgd_active <= 1'b1;
        bp(8'hC1, 8'h00, 16'h1234, 16'h0000, 3'h5, 2'h0);
        bgd_active <= 1'b0;
        nb = n_bgd;
        clk_en <= 1'b0;
        i_cpu.cycle(16'h1234, 16'h0000, 1'b1, 1'b0, 1'b1);
        clk_en <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("frozen match", 32'(n_bgd - nb), 32'h0);
    endtask : t_dir

    task automatic t_tag();
        int s;
        axi_wr(bpt_pkg::OFF_CTRL0, 32'h0000_0000);
        @(posedge aclk);
        tag_and_go_command <= 1'b1;
        @(posedge aclk);
        tag_and_go_command <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("tag_mode_active", 32'(tag_mode_active), 32'h1);
        chk("serial_cmd_block", 32'(serial_cmd_block), 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            i_cpu.tag(i[1], i[0]);
            repeat (2) @(posedge aclk);
            chk("tag_hi_out", 32'(tag_hi_out), 32'(!i[1]));
            chk("tag_lo_out", 32'(tag_lo_out), 32'(!i[0]));
            i_cpu.head(1'b1, 1'b1);
        end
        i_cpu.tag(1'b0, 1'b1);
        s = n_bgd;
        i_cpu.head(1'b0, 1'b1);
        repeat (3) @(posedge aclk);
        chk("untagged head", 32'(n_bgd - s), 32'h0);
        i_cpu.head(1'b1, 1'b0);
        repeat (3) @(posedge aclk);
        chk("tagged head", 32'(n_bgd - s), 32'h1);
        bgd_active <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("tag_mode_active", 32'(tag_mode_active), 32'h0);
        bgd_active <= 1'b0;
        axi_wr(bpt_pkg::OFF_TAG_CTRL, 32'h0000_0001);
        axi_rd(bpt_pkg::OFF_STATUS);
        chk("status", rdv, 32'h0000_0010);
    endtask : t_tag

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        clk_en = 1'b1;
        {s_axi_arvalid, s_axi_rready, bgd_active, tag_and_go_command} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_modes();
        t_second();
        t_dir();
        t_tag();
        print_verdict();
    end
endmodule : bpt_unit_bench
